// file: src/dsc_pkg.sv
// package: constants, types and command decoding for the ddr command decoder
package dsc_pkg;

  localparam int CLK_NS    = 10;
  localparam int T_RCD_NS  = 20;
  localparam int T_RP_NS   = 20;
  localparam int T_MRD_NS  = 20;
  localparam int T_WRD_NS  = 15;
  localparam int T_DPL_NS  = 15;
  localparam int T_RFC_NS  = 70;
  localparam int T_XSNR_NS = 80;

  // least times round up to whole cycles
  localparam logic [3:0] RCD_CYC   = 4'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RP_CYC    = 4'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] MRD_CYC   = 4'((T_MRD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WRD_CYC   = 4'((T_WRD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] DPL_CYC   = 4'((T_DPL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RFC_CYC   = 4'((T_RFC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] XSNR_CYC  = 4'((T_XSNR_NS + CLK_NS - 1) / CLK_NS);
  // burst of two data words takes two clocks
  localparam logic [3:0] BURST_CYC = 4'h2;

  localparam int NUM_BANKS      = 8;
  localparam int AUTO_CLOSE_BIT = 10;
  localparam int FIFO_DEPTH     = 4;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [10:0] addr;
  } dsc_cmd_pins_t;

  typedef struct packed {
    logic [2:0]  bank;
    logic [6:0]  col;
    logic [31:0] data;
    logic [3:0]  strobe;
  } dsc_beat_t;

  typedef struct packed {
    logic [2:0]  ba;
    logic [10:0] value;
  } dsc_mode_t;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_HALT, CMD_READ, CMD_WRITE, CMD_ACT, CMD_PRE, CMD_REF, CMD_MODE
  } dsc_cmd_t;

  typedef enum logic [9:0] {
    BK_IDLE     = 10'b00_0000_0001,
    BK_OPENING  = 10'b00_0000_0010,
    BK_ACTIVE   = 10'b00_0000_0100,
    BK_READ     = 10'b00_0000_1000,
    BK_READ_AC  = 10'b00_0001_0000,
    BK_WRITE    = 10'b00_0010_0000,
    BK_WRITE_AC = 10'b00_0100_0000,
    BK_WREC     = 10'b00_1000_0000,
    BK_WREC_AC  = 10'b01_0000_0000,
    BK_CLOSING  = 10'b10_0000_0000
  } dsc_bank_st_t;

  typedef enum logic [4:0] {
    GL_NORMAL  = 5'b00001,
    GL_MODESET = 5'b00010,
    GL_REFRESH = 5'b00100,
    GL_SLEEP   = 5'b01000,
    GL_PDOWN   = 5'b10000
  } dsc_glob_st_t;

  // chip_unselected_cmd and explicit nop fold into one code
  function automatic dsc_cmd_t dsc_decode(input dsc_cmd_pins_t p);
    logic [2:0] s;
    s = {p.ras_n, p.cas_n, p.we_n};
    if (p.cs_n)
      return CMD_NOP;
    unique case (s)
      3'h7:    return CMD_NOP;
      3'h6:    return CMD_HALT;
      3'h5:    return CMD_READ;
      3'h4:    return CMD_WRITE;
      3'h3:    return CMD_ACT;
      3'h2:    return CMD_PRE;
      3'h1:    return CMD_REF;
      default: return CMD_MODE;
    endcase
  endfunction

endpackage

// file: src/dsc_decoder.sv
// ddr command decoder with per-bank states and a write-beat fifo
`timescale 1ns/1ps

module dsc_fifo #(
  parameter int WIDTH = 46,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge mclk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
      rd_ptr_ff <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
      count_ff  <= (AW+1)'(count_ff + push - pop);
    end
  end
endmodule // dsc_fifo

module dsc_decoder
  import dsc_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           reset_n,
  input  wire logic           cke,
  input  dsc_pkg::dsc_cmd_pins_t cmd_pins,
  input  wire logic [3:0]     byte_mask,
  input  wire logic [31:0]    wr_data,
  output dsc_pkg::dsc_beat_t  store_beat,
  output logic                store_valid,
  input  wire logic           store_ready,
  output logic                wbuf_ready,
  output dsc_pkg::dsc_beat_t  fetch_beat,
  output logic                fetch_valid,
  output dsc_pkg::dsc_mode_t  mode_value,
  output logic                mode_load_pulse,
  output logic                all_idle,
  output logic                sleep_active,
  output logic                low_power_active,
  output logic                proto_err
);
  import dsc_pkg::*;

  dsc_bank_st_t bank_st_ff  [NUM_BANKS];
  dsc_bank_st_t nxt_bank_st [NUM_BANKS];
  logic [3:0]   bank_cnt_ff [NUM_BANKS];
  logic [3:0]   nxt_bank_cnt[NUM_BANKS];
  logic [NUM_BANKS-1:0] bank_err;
  logic [NUM_BANKS-1:0] bank_idle;
  logic [NUM_BANKS-1:0] bank_rd_go;
  logic [NUM_BANKS-1:0] bank_wr_go;
  logic [NUM_BANKS-1:0] bank_reading;
  logic [NUM_BANKS-1:0] bank_writing;

  dsc_glob_st_t glob_st_ff;
  dsc_glob_st_t nxt_glob_st;
  logic [3:0]   glob_cnt_ff;
  logic [3:0]   nxt_glob_cnt;
  logic         glob_err;
  logic         cke_prev_ff;
  logic [2:0]   bur_bank_ff;
  logic [6:0]   bur_col_ff;
  dsc_beat_t    fetch_beat_ff;
  logic         fetch_valid_ff;
  dsc_mode_t    mode_ff;
  logic         mode_pulse_ff;
  logic         err_ff;

  // pins are decoded here; every use of them is sampled on the rising edge
  wire dsc_cmd_t cmd       = dsc_decode(cmd_pins);
  wire           auto_cl   = cmd_pins.addr[AUTO_CLOSE_BIT];
  wire           cke_steady = cke_prev_ff && cke;
  wire           cmd_ok    = cke_steady && (glob_st_ff == GL_NORMAL);
  wire           any_idle  = &bank_idle;
  wire           any_rd_go = |bank_rd_go;
  wire           any_wr_go = |bank_wr_go;
  wire           writing   = |bank_writing;
  wire           reading   = |bank_reading;

  generate
    for (genvar i = 0; i < NUM_BANKS; i++)
    begin : g_bank
      wire hit       = cmd_ok && (cmd_pins.ba == 3'(i));
      wire close_all = cmd_ok && (cmd == CMD_PRE) && auto_cl;
      wire done      = (bank_cnt_ff[i] == 4'h1);

      assign bank_idle[i]    = (bank_st_ff[i] == BK_IDLE);
      assign bank_reading[i] = (bank_st_ff[i] == BK_READ) || (bank_st_ff[i] == BK_READ_AC);
      assign bank_writing[i] = (bank_st_ff[i] == BK_WRITE) || (bank_st_ff[i] == BK_WRITE_AC);

      always_comb
      begin
        nxt_bank_st[i]  = bank_st_ff[i];
        nxt_bank_cnt[i] = (bank_cnt_ff[i] != 4'h0) ? 4'(bank_cnt_ff[i] - 4'h1) : 4'h0;
        bank_err[i]     = 1'b0;
        bank_rd_go[i]   = 1'b0;
        bank_wr_go[i]   = 1'b0;
        unique case (bank_st_ff[i])
          BK_IDLE:
          begin
            if (hit && cmd == CMD_ACT)
            begin
              nxt_bank_st[i]  = BK_OPENING;
              nxt_bank_cnt[i] = RCD_CYC;
            end
            else if (hit && (cmd == CMD_READ || cmd == CMD_WRITE))
              bank_err[i] = 1'b1;
          end
          BK_OPENING:
          begin
            if (done)
              nxt_bank_st[i] = BK_ACTIVE;
            if ((hit && cmd != CMD_NOP && cmd != CMD_HALT) || close_all)
              bank_err[i] = 1'b1;
          end
          BK_ACTIVE, BK_READ, BK_WRITE:
          begin
            if (bank_reading[i] && done)
              nxt_bank_st[i] = BK_ACTIVE;
            if (bank_writing[i] && done)
            begin
              nxt_bank_st[i]  = BK_WREC;
              nxt_bank_cnt[i] = WRD_CYC;
            end
            if (hit && cmd == CMD_READ)
            begin
              // new read restarts the burst, also from a write
              nxt_bank_st[i]  = auto_cl ? BK_READ_AC : BK_READ;
              nxt_bank_cnt[i] = BURST_CYC;
              bank_rd_go[i]   = 1'b1;
            end
            else if (hit && cmd == CMD_WRITE && bank_st_ff[i] == BK_READ)
              bank_err[i] = 1'b1;
            else if (hit && cmd == CMD_WRITE)
            begin
              nxt_bank_st[i]  = auto_cl ? BK_WRITE_AC : BK_WRITE;
              nxt_bank_cnt[i] = BURST_CYC;
              bank_wr_go[i]   = 1'b1;
            end
            else if ((hit && cmd == CMD_PRE) || close_all)
            begin
              nxt_bank_st[i]  = BK_CLOSING;
              nxt_bank_cnt[i] = RP_CYC;
            end
            else if (hit && cmd == CMD_HALT && bank_st_ff[i] == BK_READ)
              nxt_bank_st[i] = BK_ACTIVE;
            else if (hit && cmd == CMD_HALT && bank_st_ff[i] == BK_WRITE)
              bank_err[i] = 1'b1;
            else if (hit && cmd == CMD_ACT)
              bank_err[i] = 1'b1;
          end
          BK_READ_AC, BK_WRITE_AC:
          begin
            if (done && bank_reading[i])
            begin
              nxt_bank_st[i]  = BK_CLOSING;
              nxt_bank_cnt[i] = RP_CYC;
            end
            else if (done)
            begin
              nxt_bank_st[i]  = BK_WREC_AC;
              nxt_bank_cnt[i] = DPL_CYC;
            end
            if ((hit && cmd != CMD_NOP) || close_all)
              bank_err[i] = 1'b1;
          end
          BK_WREC:
          begin
            if (done)
              nxt_bank_st[i] = BK_ACTIVE;
            if (hit && cmd == CMD_WRITE)
            begin
              nxt_bank_st[i]  = auto_cl ? BK_WRITE_AC : BK_WRITE;
              nxt_bank_cnt[i] = BURST_CYC;
              bank_wr_go[i]   = 1'b1;
            end
            else if ((hit && cmd != CMD_NOP && cmd != CMD_HALT) || close_all)
              bank_err[i] = 1'b1;
          end
          BK_WREC_AC:
          begin
            if (done)
            begin
              nxt_bank_st[i]  = BK_CLOSING;
              nxt_bank_cnt[i] = RP_CYC;
            end
            if ((hit && cmd != CMD_NOP) || close_all)
              bank_err[i] = 1'b1;
          end
          BK_CLOSING:
          begin
            if (done)
              nxt_bank_st[i] = BK_IDLE;
            if (hit && (cmd == CMD_READ || cmd == CMD_WRITE || cmd == CMD_ACT))
              bank_err[i] = 1'b1;
          end
          default:
          begin
            nxt_bank_st[i] = BK_IDLE;
            bank_err[i]    = 1'b1;
          end
        endcase
      end

      always_ff @(posedge mclk)
      begin
        if (!reset_n)
        begin
          bank_st_ff[i]  <= BK_IDLE;
          bank_cnt_ff[i] <= 4'h0;
        end
        else
        begin
          bank_st_ff[i]  <= nxt_bank_st[i];
          bank_cnt_ff[i] <= nxt_bank_cnt[i];
        end
      end
    end
  endgenerate

  // refresh, sleep, power-down and mode load all need every bank closed
  always_comb
  begin
    nxt_glob_st  = glob_st_ff;
    nxt_glob_cnt = (glob_cnt_ff != 4'h0) ? 4'(glob_cnt_ff - 4'h1) : 4'h0;
    glob_err     = 1'b0;
    unique case (glob_st_ff)
      GL_NORMAL:
      begin
        if (cke_prev_ff && !cke)
        begin
          if (any_idle && cmd == CMD_REF)
            nxt_glob_st = GL_SLEEP;
          else if (any_idle && cmd == CMD_NOP)
            nxt_glob_st = GL_PDOWN;
          else
            glob_err = 1'b1;
        end
        else if (cmd_ok && (cmd == CMD_REF || cmd == CMD_MODE) && !any_idle)
          glob_err = 1'b1;
        else if (cmd_ok && cmd == CMD_REF)
        begin
          nxt_glob_st  = GL_REFRESH;
          nxt_glob_cnt = RFC_CYC;
        end
        else if (cmd_ok && cmd == CMD_MODE)
        begin
          nxt_glob_st  = GL_MODESET;
          nxt_glob_cnt = MRD_CYC;
        end
      end
      GL_MODESET, GL_REFRESH:
      begin
        if (glob_cnt_ff == 4'h1)
          nxt_glob_st = GL_NORMAL;
        if (cke_steady && cmd != CMD_NOP)
          glob_err = 1'b1;
      end
      GL_SLEEP:
      begin
        if (cke)
        begin
          // exit goes through refresh recovery before idle
          nxt_glob_st  = GL_REFRESH;
          nxt_glob_cnt = XSNR_CYC;
          glob_err     = (cmd != CMD_NOP);
        end
      end
      GL_PDOWN:
      begin
        if (cke)
        begin
          nxt_glob_st = GL_NORMAL;
          glob_err    = (cmd != CMD_NOP);
        end
      end
      default:
      begin
        nxt_glob_st = GL_NORMAL;
        glob_err    = 1'b1;
      end
    endcase
  end

  // write beats are only masked with the command running
  dsc_beat_t wr_beat;
  assign wr_beat.bank   = bur_bank_ff;
  assign wr_beat.col    = bur_col_ff;
  assign wr_beat.data   = wr_data;
  assign wr_beat.strobe = ~byte_mask;
  wire wr_push = writing && cke_prev_ff;

  // store side can stall; a full buffer shows on wbuf_ready for the host
  dsc_fifo #(
    .WIDTH ($bits(dsc_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (wr_push),
    .in_ready  (wbuf_ready),
    .in_data   (wr_beat),
    .out_valid (store_valid),
    .out_ready (store_ready),
    .out_data  (store_beat)
  );

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      glob_st_ff  <= GL_NORMAL;
      glob_cnt_ff <= 4'h0;
      cke_prev_ff <= 1'b0;
      err_ff      <= 1'b0;
    end
    else
    begin
      glob_st_ff  <= nxt_glob_st;
      glob_cnt_ff <= nxt_glob_cnt;
      cke_prev_ff <= cke;
      err_ff      <= glob_err || (|bank_err) || (wr_push && !wbuf_ready);
    end
  end

  // one column pointer: only one burst owns the data lines at a time
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      bur_bank_ff <= 3'h0;
      bur_col_ff  <= 7'h00;
    end
    else if (any_rd_go || any_wr_go)
    begin
      bur_bank_ff <= cmd_pins.ba;
      bur_col_ff  <= cmd_pins.addr[6:0];
    end
    else if (reading || writing)
      bur_col_ff <= 7'(bur_col_ff + 7'h2);
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      fetch_beat_ff  <= '0;
      fetch_valid_ff <= 1'b0;
    end
    else
    begin
      fetch_valid_ff       <= reading;
      fetch_beat_ff.bank   <= bur_bank_ff;
      fetch_beat_ff.col    <= bur_col_ff;
      fetch_beat_ff.data   <= 32'h0000_0000;
      fetch_beat_ff.strobe <= 4'hf;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      mode_ff       <= '0;
      mode_pulse_ff <= 1'b0;
    end
    else
    begin
      mode_pulse_ff <= (glob_st_ff == GL_NORMAL) && (nxt_glob_st == GL_MODESET);
      if ((glob_st_ff == GL_NORMAL) && (nxt_glob_st == GL_MODESET))
      begin
        mode_ff.ba    <= cmd_pins.ba;
        mode_ff.value <= cmd_pins.addr;
      end
    end
  end

  assign fetch_beat       = fetch_beat_ff;
  assign fetch_valid      = fetch_valid_ff;
  assign mode_value       = mode_ff;
  assign mode_load_pulse  = mode_pulse_ff;
  assign all_idle         = any_idle && (glob_st_ff == GL_NORMAL);
  assign sleep_active     = (glob_st_ff == GL_SLEEP);
  assign low_power_active = (glob_st_ff == GL_PDOWN);
  assign proto_err        = err_ff;
endmodule // dsc_decoder

// file: test/dsc_decoder_asserts.sv
// checker: command, power and buffer relations seen at the decoder ports
`timescale 1ns/1ps
module dsc_decoder_asserts (
  input wire logic              mclk,
  input wire logic              reset_n,
  input wire logic              cke,
  input dsc_pkg::dsc_cmd_pins_t cmd_pins,
  input dsc_pkg::dsc_beat_t     store_beat,
  input wire logic              store_valid,
  input wire logic              store_ready,
  input dsc_pkg::dsc_mode_t     mode_value,
  input wire logic              mode_load_pulse,
  input wire logic              all_idle,
  input wire logic              sleep_active,
  input wire logic              low_power_active,
  input wire logic              proto_err
);
  import dsc_pkg::*;
  logic       cke_q_ff;
  wire  [3:0] s  = {cmd_pins.cs_n, cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n};
  // a command only counts with clock-enable high on this and the previous edge
  wire        go = cke && cke_q_ff && all_idle;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  always_ff @(posedge mclk)
    cke_q_ff <= reset_n ? cke : 1'b0;

  property p_mode_load;
    go && s == 4'h0 |=> mode_load_pulse && mode_value == {$past(cmd_pins.ba), $past(cmd_pins.addr)};
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode load not captured");
  property p_nop_quiet;
    go && (cmd_pins.cs_n || s == 4'h7) |=> !proto_err && !mode_load_pulse && all_idle;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("idle command changed state");
  property p_halt_idle;
    go && s == 4'h6 |=> !proto_err && all_idle;
  endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("halt acted outside a read");
  property p_early_rw;
    go && s[3:1] == 3'b010 |=> proto_err && all_idle;
  endproperty
  a_early_rw: assert property (p_early_rw) else $error("access to closed bank not flagged");
  property p_self_refresh;
    all_idle && cke_q_ff && !cke && s == 4'h1 |=> sleep_active && !low_power_active;
  endproperty
  a_self_refresh: assert property (p_self_refresh) else $error("self refresh not entered");
  property p_power_down;
    all_idle && cke_q_ff && !cke && cmd_pins.cs_n |=> low_power_active && !sleep_active;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power down not entered");
  property p_head_hold;
    store_valid && !store_ready |=> store_valid && $stable(store_beat);
  endproperty
  a_head_hold: assert property (p_head_hold) else $error("stalled write beat changed");
  property p_mode_back;
    $rose(mode_load_pulse) |-> ##[0:3] all_idle;
  endproperty
  a_mode_back: assert property (p_mode_back) else $error("mode load did not return idle");
endmodule // dsc_decoder_asserts

// file: test/dsc_host_model.sv
// host controller model: command pins, write beats and the drain side
`timescale 1ns/1ps
module dsc_host_model (
  input  wire logic              mclk,
  input  wire logic              stall,
  output logic                   cke,
  output dsc_pkg::dsc_cmd_pins_t cmd_pins,
  output logic [3:0]             byte_mask,
  output logic [31:0]            wr_data,
  output logic                   store_ready
);
  import dsc_pkg::*;
  initial
  begin
    cke         = 1'b1;
    cmd_pins    = '1;
    byte_mask   = 4'h0;
    wr_data     = 32'h0;
    store_ready = 1'b0;
  end

  // alternate pops so the buffer sees a slow drain; stall blocks it fully
  always @(posedge mclk)
    store_ready <= !stall && !store_ready;

  // launched after an edge, held until the next edge samples it
  task automatic cmd(input logic [3:0] code, input logic [2:0] ba, input logic [10:0] addr,
                     input logic ck = 1'b1);
    @(posedge mclk);
    cmd_pins <= code[3] ? {code, ~cmd_pins.ba, ~cmd_pins.addr} : {code, ba, addr};
    cke      <= ck;
  endtask

  task automatic beats(input logic [31:0] d0, input logic [31:0] d1,
                       input logic [3:0] m0, input logic [3:0] m1);
    wr_data   <= d0;
    byte_mask <= m0;
    @(posedge mclk);
    wr_data   <= d1;
    byte_mask <= m1;
    @(posedge mclk);
    // released lines must not keep showing the last word
    wr_data   <= ~d1;
    byte_mask <= ~m1;
  endtask
endmodule // dsc_host_model

// file: test/dsc_decoder_tb.sv
// testbench: commands, write buffer, read bursts and power modes
`timescale 1ns/1ps
module dsc_decoder_tb;
  import dsc_pkg::*;
  localparam logic [3:0] C_MODE = 4'h0, C_REF = 4'h1, C_PRE = 4'h2, C_ACT = 4'h3;
  localparam logic [3:0] C_WR = 4'h4, C_RD = 4'h5, C_HLT = 4'h6, C_DES = 4'hf;
  localparam logic [3:0] IDLE_CODES [6] = '{C_DES, 4'h7, C_HLT, C_PRE, C_RD, C_WR};
  logic          mclk, reset_n, stall, cke, store_valid, store_ready, wbuf_ready;
  logic          fetch_valid, mode_load_pulse, all_idle, sleep_active, low_power_active;
  logic          proto_err;
  logic [3:0]    byte_mask, m0, m1;
  logic [31:0]   wr_data, seed, d0, d1;
  logic [2:0]    b;
  logic [6:0]    col;
  dsc_cmd_pins_t cmd_pins;
  dsc_beat_t     store_beat, fetch_beat, exp_q[$];
  dsc_mode_t     mode_value;
  int            n_errors = 0, num_checks = 0, cyc = 0;

  dsc_host_model host_u (.mclk(mclk), .stall(stall), .cke(cke), .cmd_pins(cmd_pins),
    .byte_mask(byte_mask), .wr_data(wr_data), .store_ready(store_ready));
  dsc_decoder dut_u (.mclk(mclk), .reset_n(reset_n), .cke(cke), .cmd_pins(cmd_pins),
    .byte_mask(byte_mask), .wr_data(wr_data), .store_beat(store_beat),
    .store_valid(store_valid), .store_ready(store_ready), .wbuf_ready(wbuf_ready),
    .fetch_beat(fetch_beat), .fetch_valid(fetch_valid), .mode_value(mode_value),
    .mode_load_pulse(mode_load_pulse), .all_idle(all_idle), .sleep_active(sleep_active),
    .low_power_active(low_power_active), .proto_err(proto_err));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // a masked byte is blocked, so its strobe bit is clear
  function automatic dsc_beat_t exp_wr(input logic [2:0] bk, input logic [6:0] c,
                                       input logic [31:0] d, input logic [3:0] m);
    return '{bank: bk, col: c, data: d, strobe: ~m};
  endfunction

  task automatic report(input logic [45:0] got, input logic [45:0] exp);
    n_errors++;
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
      report(46'(got), 46'(exp));
  endtask
  task automatic chk_mode(input dsc_mode_t got, input dsc_mode_t exp);
    num_checks++;
    if (got !== exp)
      report(46'(got), 46'(exp));
  endtask
  // blocked data bytes carry no meaning and are left out
  task automatic chk_beat(input dsc_beat_t got, input dsc_beat_t exp);
    logic [31:0] keep;
    keep = {{8{exp.strobe[3]}}, {8{exp.strobe[2]}}, {8{exp.strobe[1]}}, {8{exp.strobe[0]}}};
    num_checks++;
    got.data = got.data & keep;
    exp.data = exp.data & keep;
    if (got !== exp)
      report(got, exp);
  endtask

  task automatic send(input logic [3:0] code, input logic [2:0] ba, input logic [10:0] addr);
    host_u.cmd(code, ba, addr);
    host_u.cmd(C_DES, 3'h0, 11'h0);
    #1;
  endtask
  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim && all_idle !== 1'b1; i++)
      @(posedge mclk) #1;
    chk_bit(all_idle, 1'b1);
  endtask
  task automatic fetch_chk(input logic [6:0] c);
    for (int i = 0; i < 6 && fetch_valid !== 1'b1; i++)
      @(posedge mclk) #1;
    chk_bit(fetch_valid, 1'b1);
    chk_beat(fetch_beat, '{bank: b, col: c, data: 32'h0, strobe: 4'hf});
    @(posedge mclk) #1;
    chk_bit(fetch_valid, 1'b1);
    chk_beat(fetch_beat, '{bank: b, col: c + 7'h2, data: 32'h0, strobe: 4'hf});
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      complete_run();
    end
  end

  initial
  begin
    reset_n = 1'b0;
    stall   = 1'b1;
    seed    = 32'h399e;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk_bit(wbuf_ready, 1'b1);
    send(C_PRE, 3'h0, 11'h400);
    for (int k = 0; k < 2; k++)
    begin
      seed = lfsr(seed);
      send(C_MODE, 3'(k), {1'b0, seed[9:0]});
      chk_bit(mode_load_pulse, 1'b1);
      chk_mode(mode_value, {3'(k), 1'b0, seed[9:0]});
      wait_idle(4);
    end
    for (int k = 0; k < 6; k++)
    begin
      seed = lfsr(seed);
      send(IDLE_CODES[k], seed[2:0], seed[13:3]);
      chk_bit(proto_err, k > 3);
      chk_bit(all_idle, 1'b1);
    end
    // fill the buffer with the drain stalled, then overflow it
    seed = lfsr(seed);
    b    = seed[2:0];
    col  = {1'b0, seed[7:5], 3'h0};
    send(C_ACT, b, seed[18:8]);
    chk_bit(all_idle, 1'b0);
    // a column command sampled on the edge that ends the row delay is refused
    @(posedge mclk);
    for (int k = 0; k < 3; k++)
    begin
      d0   = lfsr(seed);
      d1   = lfsr(d0);
      m0   = d1[3:0];
      m1   = d1[7:4];
      seed = d1;
      send(C_WR, b, {4'h0, col + 7'(8 * k)});
      host_u.beats(d0, d1, m0, m1);
      if (k < 2)
      begin
        exp_q.push_back(exp_wr(b, col + 7'(8 * k), d0, m0));
        exp_q.push_back(exp_wr(b, col + 7'(8 * k) + 7'h2, d1, m1));
      end
    end
    #1;
    chk_bit(wbuf_ready, 1'b0);
    chk_bit(proto_err, 1'b1);
    stall = 1'b0;
    for (int i = 0; i < 40 && exp_q.size() > 0; i++)
    begin
      @(posedge mclk) #1;
      if (store_valid === 1'b1 && store_ready === 1'b1)
        chk_beat(store_beat, exp_q.pop_front());
    end
    @(posedge mclk) #1;
    chk_bit(store_valid, 1'b0);
    chk_bit(exp_q.size() == 0, 1'b1);
    send(C_RD, b, {4'h0, col});
    fetch_chk(col);
    host_u.cmd(C_RD, b, {4'h0, col});
    send(C_WR, b, {4'h0, col});
    chk_bit(proto_err, 1'b1);
    host_u.cmd(C_RD, b, {4'h0, col});
    send(C_HLT, b, 11'h0);
    chk_bit(proto_err, 1'b0);
    @(posedge mclk) #1;
    chk_bit(fetch_valid, 1'b0);
    send(C_PRE, b, 11'h0);
    wait_idle(4);
    send(C_ACT, b, seed[18:8]);
    @(posedge mclk);
    host_u.cmd(C_WR, b, {4'h0, col});
    send(C_PRE, b, 11'h0);
    chk_bit(proto_err, 1'b0);
    wait_idle(8);
    send(C_ACT, b, seed[18:8]);
    @(posedge mclk);
    send(C_WR, b, {4'h8, col});
    wait_idle(12);
    send(C_ACT, b, seed[18:8]);
    @(posedge mclk);
    send(C_RD, b, {4'h8, col});
    fetch_chk(col);
    wait_idle(8);
    send(C_REF, 3'h0, 11'h0);
    chk_bit(all_idle, 1'b0);
    wait_idle(10);
    host_u.cmd(C_REF, 3'h0, 11'h0, 1'b0);
    host_u.cmd(C_DES, 3'h0, 11'h0, 1'b0);
    #1;
    chk_bit(sleep_active, 1'b1);
    repeat (3) host_u.cmd(C_DES, 3'h0, 11'h0, 1'b0);
    host_u.cmd(C_DES, 3'h0, 11'h0);
    host_u.cmd(C_DES, 3'h0, 11'h0);
    #1;
    wait_idle(12);
    chk_bit(sleep_active, 1'b0);
    host_u.cmd(C_DES, 3'h0, 11'h0, 1'b0);
    host_u.cmd(C_DES, 3'h0, 11'h0, 1'b0);
    #1;
    chk_bit(low_power_active, 1'b1);
    host_u.cmd(C_DES, 3'h0, 11'h0);
    host_u.cmd(C_DES, 3'h0, 11'h0);
    #1;
    wait_idle(4);
    chk_bit(low_power_active, 1'b0);
    complete_run();
  end
endmodule // dsc_decoder_tb

bind dsc_decoder dsc_decoder_asserts chk_u (.mclk(mclk), .reset_n(reset_n), .cke(cke),
  .cmd_pins(cmd_pins), .store_beat(store_beat), .store_valid(store_valid),
  .store_ready(store_ready), .mode_value(mode_value), .mode_load_pulse(mode_load_pulse),
  .all_idle(all_idle), .sleep_active(sleep_active), .low_power_active(low_power_active),
  .proto_err(proto_err));
